/* inc/acs_consts.svh */
// constants for the converter sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_ACQ_MANUAL 3'h0
`define ACS_ACQ_4TAD 3'h2
`define ACS_CONV_TADS 5'h0b
`define ACS_GAP_TADS 5'h02
`define ACS_CMP_TRIG_MODE 4'hb
`define ACS_TRIG_CMP 1'h0
`define ACS_TRIG_CTU 1'h1
`define ACS_CLK_RC_BITS 2'h3
`define ACS_RC_DIV 8'h22
`endif

/* inc/acs_pkg.sv */
// types shared by the converter sequencer files
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_IDLE,
    ACS_HOLD,
    ACS_ACQ,
    ACS_CONV,
    ACS_GAP
  } acs_state_t;
endpackage : acs_pkg

/* logic/acs_sequencer.sv */
// converter conversion sequencer top
// What this block does
// - go starts conversion or programmed acquisition
// - acquisition select 010 gives four periods
// - conversion start waits one instruction
// - completion clears go, sets done, loads result
// - discharge phase after every sample
// - software clear of go aborts, result kept
// - reset returns all state to off
// - two period gap after completion or abort
// - sleep conversion needs rc clock, extra wait
// - sleep completion wakes or powers down
// - sleep on system clock aborts conversion
// - trigger select picks compare or charge unit
// - hardware trigger acts like software start
// - triggers ignored while converter is off
// - disable bit holds converter in reset
// - conversion phase lasts eleven periods
// - done flag set regardless of interrupt enable
// - acquisition select resets to manual
// - justify select places result left or right
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module acs_sequencer #(
  parameter int RES_W = 10
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic converter_on_in,
  input wire logic go_set_in,
  input wire logic go_clr_in,
  input wire logic [2:0] acq_time_sel_in,
  input wire logic acq_time_wr_in,
  input wire logic [2:0] conv_clock_sel_in,
  input wire logic result_justify_sel_in,
  input wire logic instr_done_in,
  input wire logic sleep_in,
  input wire logic irq_en_in,
  input wire logic done_flag_clr_in,
  input wire logic trigger_source_sel_in,
  input wire logic [3:0] compare_unit_mode_in,
  input wire logic compare_unit_five_evt_in,
  input wire logic charge_time_unit_evt_in,
  input wire logic charge_time_trigger_en_in,
  input wire logic converter_disable_bit_in,
  input wire logic [RES_W-1:0] sar_data_in,
  output logic convert_go_flag_out,
  output logic conv_done_flag_out,
  output logic [2:0] acq_time_sel_out,
  output logic [7:0] result_high_out,
  output logic [7:0] result_low_out,
  output logic sample_connect_out,
  output logic discharge_out,
  output logic converting_out,
  output logic wake_out,
  output logic powered_out
);
  // elaboration check: result placement below is fixed at ten bits
  if (RES_W != 10) begin : g_bad_res_w
    $error("result width must be 10");
  end

  // local reset: module disable bit only; device reset is rstn_in
  logic mrst;
  assign mrst = converter_disable_bit_in;

  acs_pkg::acs_state_t state_r, state_nxt;
  logic [4:0] tad_cnt_r; // periods left in current phase
  logic [1:0] hold_cnt_r; // instructions still to wait
  logic go_r; // go flag
  logic done_r; // done flag
  logic [2:0] acq_r; // acquisition select
  logic [RES_W-1:0] res_r; // stored result
  logic pdown_r; // powered down after sleep
  logic rc_clk; // rc clock selected
  logic trig_evt; // selected hardware trigger
  logic start_req; // any start request
  logic abort; // abort causes
  logic tad_en; // one bit period pulse
  logic run; // divider running
  logic conv_end; // last conversion period
  logic [4:0] acq_tads; // programmed acquisition length

  // acquisition periods per select code
  function automatic logic [4:0] acs_acq_len(input logic [2:0] sel);
    logic [4:0] r;
    r = 5'h00;
    case (sel)
      3'h1: r = 5'h02;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0c;
      3'h6: r = 5'h10;
      3'h7: r = 5'h14;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : acs_acq_len

  assign rc_clk = (conv_clock_sel_in[1:0] == `ACS_CLK_RC_BITS);
  assign acq_tads = acs_acq_len(acq_r);
  // trigger selection and gating
  assign trig_evt = (trigger_source_sel_in == `ACS_TRIG_CMP) ?
      (compare_unit_five_evt_in && compare_unit_mode_in == `ACS_CMP_TRIG_MODE) :
      (charge_time_unit_evt_in && charge_time_trigger_en_in);
  // enable gates software and hardware starts alike
  assign start_req = converter_on_in && (go_set_in || trig_evt);
  // abort: software clear, enable drop, sleep without rc clock
  assign abort = go_r && (go_clr_in || !converter_on_in ||
      (sleep_in && !rc_clk));
  assign run = (state_r != acs_pkg::ACS_IDLE) && (state_r != acs_pkg::ACS_HOLD);
  assign conv_end = (state_r == acs_pkg::ACS_CONV) && tad_en &&
      (tad_cnt_r == 5'h01);

  acs_tad_gen u_tad (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .run_in(run && !mrst),
    .clk_sel_in(conv_clock_sel_in),
    .tad_en_out(tad_en)
  );

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acs_pkg::ACS_IDLE: begin
        if (start_req) begin
          state_nxt = acs_pkg::ACS_HOLD;
        end
      end
      acs_pkg::ACS_HOLD: begin
        // programmed acquisition may begin now; conversion waits instructions
        if (abort) begin
          state_nxt = acs_pkg::ACS_GAP;
        end else if (acq_r != `ACS_ACQ_MANUAL) begin
          state_nxt = acs_pkg::ACS_ACQ;
        end else if (instr_done_in && hold_cnt_r == 2'h1) begin
          state_nxt = acs_pkg::ACS_CONV;
        end
      end
      acs_pkg::ACS_ACQ: begin
        if (abort) begin
          state_nxt = acs_pkg::ACS_GAP;
        end else if (tad_en && tad_cnt_r == 5'h01) begin
          state_nxt = acs_pkg::ACS_CONV;
        end
      end
      acs_pkg::ACS_CONV: begin
        if (abort || conv_end) begin
          state_nxt = acs_pkg::ACS_GAP;
        end
      end
      acs_pkg::ACS_GAP: begin
        // capacitor discharge then channel reconnect
        if (tad_en && tad_cnt_r == 5'h01) begin
          state_nxt = acs_pkg::ACS_IDLE;
        end
      end
      default: state_nxt = acs_pkg::ACS_IDLE;
    endcase
  end

  // state and phase counter
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= acs_pkg::ACS_IDLE;
      tad_cnt_r <= 5'h00;
      hold_cnt_r <= 2'h0;
    end else if (mrst) begin
      state_r <= acs_pkg::ACS_IDLE;
      tad_cnt_r <= 5'h00;
      hold_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        case (state_nxt)
          acs_pkg::ACS_ACQ: tad_cnt_r <= acq_tads;
          acs_pkg::ACS_CONV: tad_cnt_r <= `ACS_CONV_TADS;
          acs_pkg::ACS_GAP: tad_cnt_r <= `ACS_GAP_TADS;
          default: tad_cnt_r <= 5'h00;
        endcase
      end else if (tad_en && tad_cnt_r != 5'h00) begin
        tad_cnt_r <= tad_cnt_r - 5'h01;
      end
      // rc clock adds one instruction of wait
      if (state_r == acs_pkg::ACS_IDLE) begin
        hold_cnt_r <= rc_clk ? 2'h2 : 2'h1;
      end else if (state_r == acs_pkg::ACS_HOLD && instr_done_in && hold_cnt_r > 2'h1) begin
        hold_cnt_r <= hold_cnt_r - 2'h1;
      end
    end
  end

  // go flag, done flag and result; hardware set wins over clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      go_r <= 1'b0;
      done_r <= 1'b0;
      res_r <= '0;
    end else if (mrst) begin
      go_r <= 1'b0;
      done_r <= 1'b0;
      res_r <= '0;
    end else begin
      if (conv_end && !abort) begin
        go_r <= 1'b0;
        res_r <= sar_data_in;
      end else if (abort) begin
        go_r <= 1'b0;
      end else if (start_req && state_r == acs_pkg::ACS_IDLE) begin
        go_r <= 1'b1;
      end
      if (conv_end && !abort) begin
        done_r <= 1'b1;
      end else if (done_flag_clr_in) begin
        done_r <= 1'b0;
      end
    end
  end

  // acquisition select register and sleep power state
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acq_r <= `ACS_ACQ_MANUAL;
      pdown_r <= 1'b0;
    end else if (mrst) begin
      acq_r <= `ACS_ACQ_MANUAL;
      pdown_r <= 1'b0;
    end else begin
      if (acq_time_wr_in) begin
        acq_r <= acq_time_sel_in;
      end
      if (sleep_in && ((conv_end && !irq_en_in) || (go_r && !rc_clk))) begin
        pdown_r <= 1'b1;
      end else if (!sleep_in || start_req) begin
        pdown_r <= 1'b0;
      end
    end
  end

  // wake pulse on completion in sleep with interrupt enabled
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= !mrst && sleep_in && irq_en_in && conv_end && !abort;
    end
  end

  // result placement: right justify keeps top bits zero
  assign result_high_out = result_justify_sel_in ? {6'h00, res_r[9:8]} :
      res_r[9:2];
  assign result_low_out = result_justify_sel_in ? res_r[7:0] :
      {res_r[1:0], 6'h00};
  assign convert_go_flag_out = go_r;
  assign conv_done_flag_out = done_r;
  assign acq_time_sel_out = acq_r;
  assign converting_out = (state_r == acs_pkg::ACS_CONV);
  assign discharge_out = (state_r == acs_pkg::ACS_GAP);
  assign sample_connect_out = converter_on_in && !mrst &&
      (state_r == acs_pkg::ACS_IDLE || state_r == acs_pkg::ACS_HOLD ||
       state_r == acs_pkg::ACS_ACQ);
  assign powered_out = converter_on_in && !mrst && !pdown_r;

  // assertion helpers
  logic conv_seen_r;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conv_seen_r <= 1'b0;
    end else begin
      conv_seen_r <= converting_out;
    end
  end

  a_done_sets_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (conv_end && !abort && !mrst) |=> (done_r && !go_r))
    else $error("completion did not set done and clear go");
  a_abort_keeps_res: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (abort && !mrst) |=> (res_r == $past(res_r)))
    else $error("abort changed result");
  a_off_ignores_trig: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!converter_on_in && !go_r) |=> !go_r)
    else $error("trigger accepted while off");
  a_gap_after_conv: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (converting_out && state_nxt == acs_pkg::ACS_GAP && !mrst) |=>
      (discharge_out && tad_cnt_r == 5'h02))
    else $error("gap not two periods");
  a_conv_len: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (converting_out && !conv_seen_r) |-> (tad_cnt_r == 5'h0b))
    else $error("conversion not eleven periods");
  a_disable_holds: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    mrst |=> (state_r == acs_pkg::ACS_IDLE && !go_r && !done_r))
    else $error("disable did not hold reset");
  a_acq_direct: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (state_r == acs_pkg::ACS_HOLD && acq_r == 3'h2 && !abort && !mrst) |=>
      (state_r == acs_pkg::ACS_ACQ && tad_cnt_r == 5'h04))
    else $error("acquisition length wrong");
  a_sleep_abort: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (go_r && sleep_in && !rc_clk && !mrst) |=> (!go_r && !powered_out))
    else $error("sleep on system clock did not abort");
endmodule : acs_sequencer
`default_nettype wire

/* logic/acs_tad_gen.sv */
// conversion bit period enable generator
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module acs_tad_gen (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic [2:0] clk_sel_in,
  output logic tad_en_out
);
  logic [7:0] cnt_r;
  logic [7:0] limit;
  // divide ratio minus one per clock select code
  function automatic logic [7:0] acs_div_limit(input logic [2:0] sel);
    logic [7:0] r;
    r = 8'h00;
    case (sel)
      3'h0: r = 8'h01;
      3'h4: r = 8'h03;
      3'h1: r = 8'h07;
      3'h5: r = 8'h0f;
      3'h2: r = 8'h1f;
      3'h6: r = 8'h3f;
      default: r = `ACS_RC_DIV; // rc clock modelled as a fixed divide
    endcase
    return r;
  endfunction : acs_div_limit
  assign limit = acs_div_limit(clk_sel_in);
  // counter restarts whenever the sequencer is idle so phases align
  // preload of one while idle: the enable is registered, and starting
  // from zero would stretch the first period of a phase by a cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= 8'h01;
      tad_en_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r <= 8'h01;
      tad_en_out <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r <= 8'h00;
      tad_en_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tad_en_out <= 1'b0;
    end
  end
endmodule : acs_tad_gen
`default_nettype wire

/* testbench/acs_host_model.sv */
// host core model: retires instructions while its program runs
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  output logic instr_done_out
);
  logic [1:0] cnt_r; // instruction cycle counter
  // one retired instruction every four clocks, a slow core on purpose
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= 2'h0;
      instr_done_out <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      instr_done_out <= run_in && (cnt_r == 2'h3);
    end
  end
endmodule : acs_host_model
`default_nettype wire

/* testbench/acs_sequencer_bench.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module acs_sequencer_bench;
  // stimulus, all driven at the rising edge
  logic clk = 0, rstn = 0, on = 0, gs = 0, gc = 0, aw = 0, just = 0, slp = 0, irq = 0;
  logic dclr = 0, tsel = 0, cmp = 0, ctu = 0, cten = 0, dis = 0, run = 0;
  logic [2:0] acq = 0, csel = 0;
  logic [3:0] mode = 0;
  logic [9:0] sar = 0;
  // observed outputs
  logic go, done, conn, dis_o, conv, wake, pwr, instr;
  logic [2:0] acq_o;
  logic [7:0] rh, rl;
  int num_errors = 0, checks = 0, wakes = 0;
  logic [2:0] cs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6}; // every system clock divide
  always #25 clk = ~clk;
  // wake is a one-cycle pulse, so count it as it goes by
  always @(negedge clk) if (wake === 1'b1) wakes++;
  acs_host_model u_acs_host_model (.ref_clk_in(clk), .rstn_in(rstn), .run_in(run),
    .instr_done_out(instr));
  acs_sequencer u_acs_sequencer (.ref_clk_in(clk), .rstn_in(rstn), .converter_on_in(on),
    .go_set_in(gs), .go_clr_in(gc), .acq_time_sel_in(acq), .acq_time_wr_in(aw),
    .conv_clock_sel_in(csel), .result_justify_sel_in(just), .instr_done_in(instr),
    .sleep_in(slp), .irq_en_in(irq), .done_flag_clr_in(dclr), .trigger_source_sel_in(tsel),
    .compare_unit_mode_in(mode), .compare_unit_five_evt_in(cmp),
    .charge_time_unit_evt_in(ctu), .charge_time_trigger_en_in(cten),
    .converter_disable_bit_in(dis), .sar_data_in(sar), .convert_go_flag_out(go),
    .conv_done_flag_out(done), .acq_time_sel_out(acq_o), .result_high_out(rh),
    .result_low_out(rl), .sample_connect_out(conn), .discharge_out(dis_o),
    .converting_out(conv), .wake_out(wake), .powered_out(pwr));
  // clocks per bit period for a divide code
  function int div(input logic [2:0] c);
    if (c[1:0] == 2'h3) return 35;
    return 2 << (c[1] * 4 + c[0] * 2 + c[2]);
  endfunction : div
  // programmed acquisition periods per select code
  function automatic int alen(input logic [2:0] a);
    int t [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return t[a];
  endfunction : alen
  // expected result pair for a justify choice
  function logic [15:0] fmt(input logic [9:0] r, input logic j);
    return j ? {6'h0, r} : {r, 6'h0};
  endfunction : fmt
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one full conversion; hold delays the core, sl sleeps once converting
  task run_conv(input logic [2:0] c, input logic [9:0] d, input logic j, input int hold,
      input logic sl);
    int na, nc, ng, w0, al;
    na = 0;
    nc = 1;
    ng = 0;
    w0 = wakes;
    @(posedge clk); csel <= c; sar <= d; just <= j; gs <= 1; run <= (hold == 0);
    @(posedge clk); gs <= 0;
    if (hold > 0) begin
      tick(hold);
      @(negedge clk);
      `CHK(conv, 1'b0)
      `CHK(go, 1'b1)
      @(posedge clk); run <= 1;
      // first retired instruction starts it, unless the rc clock wants one more
      while (instr !== 1'b1) @(negedge clk);
      @(negedge clk);
      `CHK(conv, c[1:0] != 2'h3)
    end
    while (conv !== 1'b1) begin @(negedge clk); na++; end
    al = alen(acq_o) * div(c);
    if (acq_o !== 3'h0) `CHK(na >= al && na <= al + 4, 1'b1)
    do begin @(posedge clk); slp <= sl; @(negedge clk); if (conv === 1'b1) nc++; end
    while (conv === 1'b1);
    `CHK(nc, 11 * div(c))
    `CHK(go, 1'b0)
    `CHK(done, 1'b1)
    `CHK({rh, rl}, fmt(d, j))
    `CHK(conn, 1'b0)
    while (dis_o === 1'b1) begin @(negedge clk); ng++; end
    `CHK(ng, 2 * div(c))
    `CHK(conn, 1'b1)
    if (sl) `CHK(irq ? (wakes > w0) : (pwr === 1'b0), 1'b1)
    @(posedge clk); slp <= 0; run <= 0; dclr <= 1;
    @(posedge clk); dclr <= 0;
    @(negedge clk);
    `CHK(done, 1'b0)
    `CHK(pwr, 1'b1)
    tick(2);
  endtask : run_conv
  // abort mid-conversion: 0 go clear, 1 enable off, 2 sleep, 3 disable, 4 device reset
  task abort_run(input int k);
    logic [15:0] prev;
    prev = {rh, rl};
    @(posedge clk); csel <= 3'h0; gs <= 1; run <= 1;
    @(posedge clk); gs <= 0;
    while (conv !== 1'b1) @(negedge clk);
    @(posedge clk); gc <= (k == 0); on <= (k != 1); slp <= (k == 2); dis <= (k == 3);
    rstn <= (k != 4);
    @(posedge clk); gc <= 0; run <= 0;
    tick(2);
    @(negedge clk);
    `CHK(go, 1'b0)
    `CHK({rh, rl}, (k >= 3) ? 16'h0 : prev)
    if (k == 2) `CHK(pwr, 1'b0)
    @(posedge clk); on <= 1; slp <= 0; dis <= 0;
    rstn <= 1;
    tick(12);
  endtask : abort_run
  task print_verdict;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // cut a hang short well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(32'h6a85));
    tick(12);
    rstn <= 1;
    @(negedge clk);
    `CHK(go, 1'b0)
    `CHK(done, 1'b0)
    `CHK(acq_o, 3'h0)
    `CHK({rh, rl}, 16'h0)
    @(posedge clk); on <= 1; // enable first, start later
    tick(2);
    run_conv(3'h0, 10'h3ff, 1'b1, 20, 1'b0);
    for (int i = 0; i < 12; i++) run_conv(cs[i % 6], 10'($urandom), 1'($urandom), 0, 1'b0);
    // every programmed acquisition length once
    for (int a = 1; a < 8; a++) begin
      @(posedge clk); acq <= 3'(a); aw <= 1;
      @(posedge clk); aw <= 0;
      run_conv(3'h0, 10'($urandom), 1'($urandom), 0, 1'b0);
    end
    @(posedge clk); acq <= 3'h2; aw <= 1;
    @(posedge clk); aw <= 0;
    @(negedge clk);
    `CHK(acq_o, 3'h2)
    run_conv(3'h4, 10'h155, 1'b0, 0, 1'b0);
    @(posedge clk); acq <= 3'h0; aw <= 1;
    @(posedge clk); aw <= 0;
    for (int k = 0; k < 5; k++) abort_run(k);
    // hardware triggers against 24 random draws of source, mode, enable and on settings
    for (int i = 0; i < 24; i++) begin
      bit s, e, o, m, w;
      logic ex;
      {s, e, o, m, w} = 5'($urandom);
      @(posedge clk); tsel <= s; cten <= e; on <= o; mode <= m ? 4'hb : 4'h9;
      @(posedge clk); cmp <= w; ctu <= !w;
      @(posedge clk); cmp <= 0; ctu <= 0;
      ex = o && (s ? (e && !w) : (m && w));
      tick(1);
      @(negedge clk);
      `CHK(go, ex)
      @(posedge clk); gc <= 1; on <= 1;
      @(posedge clk); gc <= 0;
      tick(8);
    end
    // sleep conversions on the rc clock, first powering down, then waking
    run_conv(3'h3, 10'h2a5, 1'b1, 4, 1'b1);
    @(posedge clk); irq <= 1;
    run_conv(3'h3, 10'h0c3, 1'b0, 0, 1'b1);
    print_verdict();
  end
endmodule : acs_sequencer_bench
`default_nettype wire
